/* File: hw/bsdic_top.sv */
`timescale 1ns/100ps
// How it works
// - Boost runs adaptive or manual with user boost value, in either direction.
// - Adaptive mode sweeps boost, keeps widest eye, then declares lock.
// - Lock holds after adaptation even with eye monitor turned off.
// - Manual mode ignores monitor; host may disable it any time.
// - Receive: coax input equalised to host output, aux optional.
// - Transmit: pcb input drives coax port and aux output.
// - Reclocker retimes supported rates, bypasses others by itself.
// - Floating bus strap picks SPI, low level picks SMBus.
// - Direction strap low gives receive, high gives transmit.
// - Host output strap disables only in transmit direction.
// - Aux strap low enables aux output, high disables it.
// - Direction may change in service by strap or register.
// - Receive with loop-through: reclocked copy on aux and host.
module bsdic_top #(
  parameter int BOOST_W = 4
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Straps
  input wire logic [1:0] direction_select_strap_i,
  input wire logic [1:0] host_output_select_strap_i,
  input wire logic [1:0] aux_output_select_strap_i,
  input wire logic [1:0] bus_select_strap_i,
  // Host register settings
  input wire bsdic_pkg::bsdic_ovr_t ovr_i,
  input wire logic adaptive_boost_mode_i,
  input wire logic [BOOST_W-1:0] manual_boost_i,
  input wire logic eye_monitor_en_i,
  // Analog side status
  input wire logic [BOOST_W-1:0] eye_metric_i,
  input wire logic rate_valid_i,
  input wire logic [2:0] rate_code_i,
  // Serial data
  input wire logic pcb_input_i,
  input wire logic coax_io_port_i,
  // Outputs
  output logic coax_io_port_o,
  output logic coax_io_port_oe_o,
  output logic aux_coax_output_o,
  output logic aux_coax_output_en_o,
  output logic host_output_o,
  output logic host_output_en_o,
  output logic tx_direction_o,
  output logic spi_sel_o,
  output logic [BOOST_W-1:0] boost_o,
  output logic eye_monitor_on_o,
  output logic lock_o,
  output logic reclock_bypass_o
);

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  bsdic_pkg::bsdic_route_t next_route;
  logic supported_rate;

  // Strap levels, with register overrides on top
  always_comb begin
    next_route.tx_dir = (direction_select_strap_i == bsdic_pkg::BSDIC_LVL_H);
    if (ovr_i.dir_ovr_en) begin
      next_route.tx_dir = ovr_i.dir_tx;
    end
    next_route.host_out_en = 1'b1;
    if (next_route.tx_dir) begin
      next_route.host_out_en = ovr_i.host_ovr_en ? ovr_i.host_en :
        (host_output_select_strap_i == bsdic_pkg::BSDIC_LVL_L);
    end
    next_route.aux_out_en = ovr_i.aux_ovr_en ? ovr_i.aux_en :
      (aux_output_select_strap_i == bsdic_pkg::BSDIC_LVL_L);
    next_route.coax_drv_en = next_route.tx_dir;
    next_route.src_is_pcb = next_route.tx_dir;
  end

  // Supported rates and their subrates
  always_comb begin
    case (rate_code_i)
      bsdic_pkg::BSDIC_RATE_3G, bsdic_pkg::BSDIC_RATE_3G_SUB,
      bsdic_pkg::BSDIC_RATE_HD, bsdic_pkg::BSDIC_RATE_HD_SUB,
      bsdic_pkg::BSDIC_RATE_SD: supported_rate = rate_valid_i;
      default: supported_rate = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Boost adaptation
  // ---------------------------------------------------------------
  bsdic_pkg::bsdic_state_t state;
  logic [BOOST_W-1:0] try_boost;
  logic [BOOST_W-1:0] best_boost;
  logic [BOOST_W-1:0] best_metric;
  logic [3:0] settle;
  logic tx_q;
  logic adapt_q;

  // Adaptive sweep, manual load and lock hold
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state <= bsdic_pkg::BSDIC_ST_IDLE;
      try_boost <= '0;
      best_boost <= '0;
      best_metric <= '0;
      settle <= 4'h0;
      boost_o <= bsdic_pkg::BSDIC_BOOST_RST[BOOST_W-1:0];
      lock_o <= 1'b0;
      tx_q <= 1'b0;
      adapt_q <= 1'b0;
    end else if (ce_i) begin
      tx_q <= next_route.tx_dir;
      adapt_q <= adaptive_boost_mode_i;
      if ((tx_q != next_route.tx_dir) ||
          (adapt_q != adaptive_boost_mode_i) || !supported_rate) begin
        state <= bsdic_pkg::BSDIC_ST_IDLE; // Restart on change
        lock_o <= 1'b0;
      end else begin
        case (state)
          bsdic_pkg::BSDIC_ST_IDLE: begin
            if (!adaptive_boost_mode_i) begin
              boost_o <= manual_boost_i;
              state <= bsdic_pkg::BSDIC_ST_APPLY;
            end else if (eye_monitor_en_i) begin
              try_boost <= '0;
              best_metric <= '0;
              best_boost <= '0;
              boost_o <= '0;
              state <= bsdic_pkg::BSDIC_ST_SWEEP;
            end
            settle <= 4'h0;
          end
          bsdic_pkg::BSDIC_ST_SWEEP: begin
            settle <= settle + 4'h1;
            if (settle == 4'(bsdic_pkg::BSDIC_SETTLE_CYC - 1)) begin
              settle <= 4'h0;
              if (eye_metric_i > best_metric) begin
                best_metric <= eye_metric_i;
                best_boost <= try_boost;
              end
              if (try_boost == bsdic_pkg::BSDIC_BOOST_MAX[BOOST_W-1:0])
              begin
                state <= bsdic_pkg::BSDIC_ST_APPLY;
              end else begin
                try_boost <= try_boost + 1'b1;
                boost_o <= try_boost + 1'b1;
              end
            end
          end
          bsdic_pkg::BSDIC_ST_APPLY: begin
            if (adaptive_boost_mode_i) begin
              boost_o <= best_boost;
            end
            lock_o <= 1'b1;
            state <= bsdic_pkg::BSDIC_ST_LOCK;
          end
          bsdic_pkg::BSDIC_ST_LOCK: begin
            lock_o <= 1'b1;
            if (!adaptive_boost_mode_i) begin
              boost_o <= manual_boost_i;
            end
          end
          default: state <= bsdic_pkg::BSDIC_ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Data path and configuration outputs
  // ---------------------------------------------------------------
  logic src_bit;
  logic retimed;

  always_comb begin
    src_bit = next_route.src_is_pcb ? pcb_input_i : coax_io_port_i;
  end

  // Reclocker stage, bypassed on unsupported rates
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      retimed <= 1'b0;
      reclock_bypass_o <= 1'b1;
    end else if (ce_i) begin
      retimed <= src_bit;
      reclock_bypass_o <= !supported_rate;
    end
  end

  // Output routing per direction
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      coax_io_port_o <= 1'b0;
      coax_io_port_oe_o <= 1'b0;
      aux_coax_output_o <= 1'b0;
      aux_coax_output_en_o <= 1'b0;
      host_output_o <= 1'b0;
      host_output_en_o <= 1'b0;
      tx_direction_o <= 1'b0;
      spi_sel_o <= 1'b0;
      eye_monitor_on_o <= 1'b0;
    end else if (ce_i) begin
      coax_io_port_o <= (supported_rate ? retimed : src_bit) &
        next_route.coax_drv_en;
      coax_io_port_oe_o <= next_route.coax_drv_en;
      aux_coax_output_o <= (supported_rate ? retimed : src_bit) &
        next_route.aux_out_en;
      aux_coax_output_en_o <= next_route.aux_out_en;
      host_output_o <= (supported_rate ? retimed : src_bit) &
        next_route.host_out_en;
      host_output_en_o <= next_route.host_out_en;
      tx_direction_o <= next_route.tx_dir;
      spi_sel_o <= (bus_select_strap_i != bsdic_pkg::BSDIC_LVL_L);
      // Monitor only draws power when asked for
      eye_monitor_on_o <= eye_monitor_en_i;
    end
  end

endmodule // bsdic_top

/* File: hw/bsdic_pkg.sv */
package bsdic_pkg;

  // ---------------------------------------------------------------
  // Strap levels and rate codes
  // ---------------------------------------------------------------
  localparam logic [1:0] BSDIC_LVL_L = 2'h0; // Pulled low
  localparam logic [1:0] BSDIC_LVL_H = 2'h1; // Pulled high
  localparam logic [1:0] BSDIC_LVL_F = 2'h2; // Left floating

  localparam logic [2:0] BSDIC_RATE_3G = 3'h0;
  localparam logic [2:0] BSDIC_RATE_3G_SUB = 3'h1;
  localparam logic [2:0] BSDIC_RATE_HD = 3'h2;
  localparam logic [2:0] BSDIC_RATE_HD_SUB = 3'h3;
  localparam logic [2:0] BSDIC_RATE_SD = 3'h4;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [3:0] BSDIC_BOOST_RST = 4'h0;
  localparam logic [3:0] BSDIC_BOOST_MAX = 4'hF;
  localparam int BSDIC_SETTLE_NS = 64;
  localparam int BSDIC_CLK_NS = 8;
  localparam int BSDIC_SETTLE_CYC = BSDIC_SETTLE_NS / BSDIC_CLK_NS;

  // Adaptation controller states
  typedef enum logic [3:0] {
    BSDIC_ST_IDLE = 4'h1,
    BSDIC_ST_SWEEP = 4'h2,
    BSDIC_ST_APPLY = 4'h4,
    BSDIC_ST_LOCK = 4'h8
  } bsdic_state_t;

  // Host register overrides
  typedef struct packed {
    logic dir_ovr_en;
    logic dir_tx;
    logic host_ovr_en;
    logic host_en;
    logic aux_ovr_en;
    logic aux_en;
  } bsdic_ovr_t;

  // Routing result
  typedef struct packed {
    logic tx_dir;
    logic coax_drv_en;
    logic host_out_en;
    logic aux_out_en;
    logic src_is_pcb;
  } bsdic_route_t;

endpackage

/* File: testbench/bsdic_top_monitor.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module bsdic_top_monitor (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Straps, overrides, status
  input wire logic [1:0] direction_select_strap_i,
  input wire logic [1:0] host_output_select_strap_i,
  input wire logic [1:0] aux_output_select_strap_i,
  input wire logic [1:0] bus_select_strap_i,
  input wire bsdic_pkg::bsdic_ovr_t ovr_i,
  input wire logic eye_monitor_en_i,
  input wire logic rate_valid_i,
  input wire logic [2:0] rate_code_i,
  // Watched outputs
  input wire logic coax_io_port_oe_o,
  input wire logic aux_coax_output_en_o,
  input wire logic host_output_en_o,
  input wire logic tx_direction_o,
  input wire logic spi_sel_o,
  input wire logic eye_monitor_on_o,
  input wire logic lock_o,
  input wire logic reclock_bypass_o
);
  localparam logic [1:0] LV_L = bsdic_pkg::BSDIC_LVL_L;
  localparam logic [1:0] LV_H = bsdic_pkg::BSDIC_LVL_H;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // Decoded outputs follow their inputs one edge later
  chk_dir_tx: assert property (ce_i && !ovr_i.dir_ovr_en
    && direction_select_strap_i == LV_H
    |=> tx_direction_o && coax_io_port_oe_o) else $error("tx strap");
  chk_dir_rx: assert property (ce_i && !ovr_i.dir_ovr_en
    && direction_select_strap_i == LV_L
    |=> !coax_io_port_oe_o && host_output_en_o) else $error("rx strap");
  chk_dir_ovr: assert property (ce_i && ovr_i.dir_ovr_en
    |=> tx_direction_o == $past(ovr_i.dir_tx)) else $error("dir ovr");
  chk_host_off: assert property (ce_i && ovr_i == '0
    && direction_select_strap_i == LV_H
    && host_output_select_strap_i == LV_H
    |=> !host_output_en_o) else $error("host off");
  chk_aux_off: assert property (ce_i && !ovr_i.aux_ovr_en
    && aux_output_select_strap_i == LV_H
    |=> !aux_coax_output_en_o) else $error("aux off");
  chk_bus_sel: assert property (ce_i
    |=> spi_sel_o == ($past(bus_select_strap_i) != LV_L)) else $error("bus");
  chk_rate_bypass: assert property (ce_i && rate_valid_i
    |=> reclock_bypass_o ==
    ($past(rate_code_i) > bsdic_pkg::BSDIC_RATE_SD)) else $error("bypass");
  chk_mon_power: assert property (ce_i
    |=> eye_monitor_on_o == $past(eye_monitor_en_i)) else $error("monitor");
  chk_lock_keep: assert property (ce_i && lock_o
    && $fell(eye_monitor_en_i) |=> lock_o) else $error("lock lost");
endmodule // bsdic_top_monitor
bind bsdic_top bsdic_top_monitor i_mon (.clock_i, .resetn_i, .ce_i,
  .direction_select_strap_i, .host_output_select_strap_i,
  .aux_output_select_strap_i, .bus_select_strap_i, .ovr_i,
  .eye_monitor_en_i, .rate_valid_i, .rate_code_i, .coax_io_port_oe_o,
  .aux_coax_output_en_o, .host_output_en_o, .tx_direction_o, .spi_sel_o,
  .eye_monitor_on_o, .lock_o, .reclock_bypass_o);

/* File: testbench/bsdic_host_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Host transceiver model
// ----------------------------------------
module bsdic_host_model (
  // Clock and device status
  input wire logic clock_i,
  input wire logic lock_i,
  input wire logic power_save_i,
  input wire logic manual_i,
  // Lines to the device
  output logic pcb_input_o,
  output logic eye_monitor_en_o
);
  localparam logic [2:0] PAGE_EQ = 3'h4; // Equaliser/reclocker page
  logic [3:0] pat = 4'h9;
  logic [2:0] page = 3'h0;
  // Serial pattern launched off the falling edge
  always @(negedge clock_i) pat <= {pat[2:0], pat[3] ^ pat[2]};
  assign pcb_input_o = pat[3];
  // Page selected before any equaliser register is touched
  always @(posedge clock_i) page <= PAGE_EQ;
  // Adaptive: monitor off only after lock; manual: off at any time
  always @(posedge clock_i) begin
    if (page == PAGE_EQ) begin
      eye_monitor_en_o <= !(power_save_i && (lock_i || manual_i));
    end
  end
endmodule // bsdic_host_model

/* File: testbench/bsdic_top_test.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Mode and routing bench
// ----------------------------------------
module bsdic_top_test;
  logic clk = 0, rst_n = 0, ce = 1, ad = 0, ps = 0, rv = 1, ci = 0, pi, me;
  logic [1:0] ds = '0, hs = '0, xs = '0, bs = '0, hp = '0, hc = '0;
  logic [2:0] rc = '0;
  logic [3:0] mb = 4'h5, em = '0, bo;
  logic co, coe, ao, aen, ho, hen, tx, spi, lk, byp, mo;
  bsdic_pkg::bsdic_ovr_t ov = '0;
  int n_errors = 0, tests_run = 0;
  // Clock, serial history, eye metric peaking at boost 9
  always #4 clk = ~clk;
  always @(posedge clk) hp <= {hp[0], pi};
  always @(posedge clk) hc <= {hc[0], ci};
  always @(negedge clk) ci <= ~ci ^ pi;
  always @(negedge clk) em <= (bo == 4'h9) ? 4'hC : 4'h3;
  bsdic_host_model i_host (.clock_i(clk), .lock_i(lk), .power_save_i(ps),
    .manual_i(!ad), .pcb_input_o(pi), .eye_monitor_en_o(me));
  bsdic_top i_dut (.clock_i(clk), .resetn_i(rst_n), .ce_i(ce),
    .direction_select_strap_i(ds), .host_output_select_strap_i(hs),
    .aux_output_select_strap_i(xs), .bus_select_strap_i(bs), .ovr_i(ov),
    .adaptive_boost_mode_i(ad), .manual_boost_i(mb), .eye_monitor_en_i(me),
    .eye_metric_i(em), .rate_valid_i(rv), .rate_code_i(rc), .pcb_input_i(pi),
    .coax_io_port_i(ci), .coax_io_port_o(co), .coax_io_port_oe_o(coe),
    .aux_coax_output_o(ao), .aux_coax_output_en_o(aen), .host_output_o(ho),
    .host_output_en_o(hen), .tx_direction_o(tx), .spi_sel_o(spi),
    .boost_o(bo), .eye_monitor_on_o(mo), .lock_o(lk),
    .reclock_bypass_o(byp));
  task chk(input string n, input logic [3:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task st(input int n);
    repeat (n) @(negedge clk);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wlock;
    for (int i = 0; i < 400 && lk !== 1'b1; i++) st(1);
    chk("lock_wait", lk, 4'h1);
    if (lk !== 1'b1) conclude;
  endtask
  // Every low/high combination of direction, host and aux straps, then all three bus strap levels
  task t_straps;
    for (int k = 0; k < 8; k++) begin
      {ds[0], hs[0], xs[0]} = 3'(k);
      st(2);
      chk("dir", tx, 4'(k[2]));
      chk("coax_oe", coe, 4'(k[2]));
      chk("host_en", hen, 4'(!(k[2] && k[1])));
      chk("aux_en", aen, 4'(!k[0]));
    end
    for (int b = 0; b < 3; b++) begin
      bs = 2'(b);
      st(2);
      chk("spi", spi, 4'(b != 0));
    end
    $display("done straps");
  endtask
  // Overrides, change in service, frozen by enable
  task t_ovr;
    ds = '0;
    ov.dir_ovr_en = 1;
    ov.dir_tx = 1;
    st(2);
    chk("ovr_tx", tx, 4'h1);
    ov = '0;
    st(2);
    chk("strap_rx", tx, 4'h0);
    ce = 0;
    ds = 2'h1;
    st(3);
    chk("frozen", tx, 4'h0);
    ce = 1;
    st(2);
    chk("strap_tx", tx, 4'h1);
    // Output enable overrides beat the disabling straps
    ov = 6'h0F;
    st(2);
    chk("host_ovr", hen, 4'h1);
    chk("aux_ovr", aen, 4'h1);
    ds = '0;
    ov = 6'h0A;
    st(2);
    chk("host_rx_on", hen, 4'h1);
    chk("aux_ovr_off", aen, 4'h0);
    ov = '0;
    ds = 2'h1;
    for (int r = 0; r < 8; r++) begin
      rc = 3'(r);
      st(2);
      chk("bypass", byp, 4'(r > 4));
    end
    rc = '0;
    rv = 0;
    st(2);
    chk("bypass_nv", byp, 4'h1);
    rv = 1;
    $display("done overrides");
  endtask
  // Serial routing in both directions
  task t_data;
    {ds, hs, xs} = 6'h10;
    st(4);
    repeat (8) begin
      st(1);
      chk("coax_tx", co, 4'(hp[1]));
      chk("aux_tx", ao, 4'(hp[1]));
    end
    // Unsupported rate passes straight through, one edge sooner
    rc = 3'h7;
    st(2);
    repeat (4) begin
      st(1);
      chk("coax_byp", co, 4'(hp[0]));
    end
    rc = '0;
    ds = '0;
    st(4);
    repeat (8) begin
      st(1);
      chk("host_rx", ho, 4'(hc[1]));
      chk("aux_rx", ao, 4'(hc[1]));
    end
    $display("done data");
  endtask
  // Adaptive sweep then manual boost, monitor dropped after lock
  task t_lock;
    ds = 2'h1;
    ad = 1;
    st(2);
    wlock;
    chk("boost_ad", bo, 4'h9);
    chk("mon_on", mo, 4'h1);
    ps = 1;
    st(20);
    chk("lock_ad", lk, 4'h1);
    chk("mon_off", mo, 4'h0);
    ad = 0;
    st(2);
    wlock;
    chk("boost_man", bo, 4'h5);
    st(20);
    chk("lock_man", lk, 4'h1);
    chk("mon_man", mo, 4'h0);
    $display("done lock");
  endtask
  initial begin
    st(5);
    chk("bypass_rst", byp, 4'h1);
    rst_n = 1;
    t_straps;
    t_ovr;
    t_data;
    t_lock;
    conclude;
  end
endmodule // bsdic_top_test
